// File: design/viu_consts.vh
// constants for the vectored interrupt and exception unit
`ifndef VIU_CONSTS_VH
`define VIU_CONSTS_VH
// ==========================================
// register offsets (byte addresses, word aligned)
`define VIU_OFF_MASK_LO 8'h00
`define VIU_OFF_MASK_HI 8'h04
`define VIU_OFF_PEND_LO 8'h08
`define VIU_OFF_PEND_HI 8'h0C
`define VIU_OFF_EDGE_MODE 8'h10
`define VIU_OFF_PORT0 8'h14
`define VIU_OFF_CAP_SEL 8'h18
`define VIU_OFF_STATUS 8'h1C
`define VIU_OFF_PRIO_BASE 8'h40
// ==========================================
// field positions and reset values
`define VIU_NMI_EDGE_BIT 0
`define VIU_MASK_RST 32'hFFFFFFFF
`define VIU_PRIO_RST 3'h7
`define VIU_EDGE_RST 32'h00000000
`define VIU_NUM_SRC 47
`define VIU_NUM_EXT 11
`define VIU_CAP_SRC 12
// ==========================================
// exception codes and handler addresses
`define VIU_CODE_RESET 16'h0000
`define VIU_CODE_NMI 16'h0010
`define VIU_CODE_TRAP_LO 16'h0040
`define VIU_CODE_TRAP_HI 16'h0050
`define VIU_CODE_ILG 16'h0060
`define VIU_ILG_PC_OFS 32'h00000004
// ==========================================
// timing: least latency from request to handler
`define VIU_MIN_LAT_CYC 4
`define VIU_FILT_LEN 3
`endif

// File: design/viu_edge_filter.v
// noise filter and selectable edge detector for one external request pin
`timescale 1ns/100ps
`default_nettype none
`include "viu_consts.vh"
module viu_edge_filter (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire pin_i,
	input wire rise_sel_i,
	output reg edge_o
);
	// ==========================================
	// shift history; level accepted when all samples agree
	reg [`VIU_FILT_LEN-1:0] hist_reg;
	reg level_reg;
	wire all_one = &hist_reg;
	wire all_zero = ~|hist_reg;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist_reg <= {`VIU_FILT_LEN{1'b1}};
			level_reg <= 1'b1;
			edge_o <= 1'b0;
		end else begin
			hist_reg <= {hist_reg[`VIU_FILT_LEN-2:0], pin_i};
			// stable levels only; glitches shorter than the window vanish
			if (all_one) begin
				level_reg <= 1'b1;
			end else if (all_zero) begin
				level_reg <= 1'b0;
			end
			edge_o <= rise_sel_i ? (all_one & ~level_reg) : (all_zero & level_reg);
		end
	end
endmodule
`default_nettype wire

// File: design/viu_prio_pick.v
// picks the winning pending maskable request by level, then by default order
`timescale 1ns/100ps
`default_nettype none
`include "viu_consts.vh"
module viu_prio_pick (
	input wire [`VIU_NUM_SRC-1:0] cand_i,
	input wire [3*`VIU_NUM_SRC-1:0] prio_i,
	output reg found_o,
	output reg [5:0] idx_o,
	output reg [2:0] lvl_o
);
	integer k;
	// scan from lowest default number; strict compare keeps the lower number on ties
	always @* begin
		found_o = 1'b0;
		idx_o = 6'h00;
		lvl_o = 3'h7;
		for (k = 0; k < `VIU_NUM_SRC; k = k + 1) begin
			if (cand_i[k] && (!found_o || prio_i[3*k +: 3] < lvl_o)) begin
				found_o = 1'b1;
				idx_o = k[5:0];
				lvl_o = prio_i[3*k +: 3];
			end
		end
	end
endmodule
`default_nettype wire

// File: design/viu_core.v
// top of the vectored interrupt and exception unit with its register slave
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "viu_consts.vh"
module viu_core (
	input wire core_clk_i,
	input wire rst_n_i,
	// avalon-mm slave
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	// request sources
	input wire port0_bit0_pin_i,
	input wire [`VIU_NUM_EXT-1:0] ext_pin_i,
	input wire capture_request_a_i,
	input wire capture_request_b_i,
	input wire [`VIU_NUM_SRC-1:0] periph_req_i,
	// cpu side
	input wire [31:0] following_instruction_address_i,
	input wire [31:0] current_instruction_address_i,
	input wire abortable_insn_i,
	input wire trap_i,
	input wire [4:0] trap_vector_i,
	input wire illegal_or_debug_trap_i,
	input wire psw_id_i,
	input wire psw_np_i,
	input wire reti_i,
	output reg take_o,
	output reg [15:0] exc_code_o,
	output reg [31:0] handler_o,
	output reg [31:0] maskable_return_save_o,
	output reg [31:0] nonmaskable_return_save_o,
	output reg [31:0] debug_return_save_o,
	output reg [2:0] in_service_lvl_o,
	output reg in_service_o
);
	// ==========================================
	// source slot map: default number to vector slot
	function [7:0] slot_of;
		input [5:0] n;
		begin
			if (n < 6'd5) slot_of = {2'b00, n} + 8'h08;
			else if (n < 6'd15) slot_of = {2'b00, n} + 8'h0A;
			else if (n < 6'd31) slot_of = {2'b00, n} + 8'h0E;
			else if (n < 6'd38) slot_of = {2'b00, n} + 8'h12;
			else if (n < 6'd40) slot_of = {2'b00, n} + 8'h14;
			else slot_of = {2'b00, n} + 8'h17;
		end
	endfunction
	// external pin sources: default numbers 0..4, 12 (capture), 17..21 mapped below
	// ==========================================
	// registers
	reg [`VIU_NUM_SRC-1:0] mask_reg; // set = masked
	reg [`VIU_NUM_SRC-1:0] pend_reg; // latched events
	reg [3*`VIU_NUM_SRC-1:0] prio_reg; // 3 bits per source
	reg [`VIU_NUM_EXT:0] edge_mode_reg; // bit0 nmi, others ext pins
	reg capture_pin_select_reg; // 0 = pin a, 1 = pin b
	reg nmi_pend_reg;
	reg nmi_busy_reg;
	reg [`VIU_NUM_SRC-1:0] isr_reg; // in-service per source
	reg [7:0] isp_reg; // in-service per level
	reg [2:0] lat_cnt_reg; // counts cycles a request has waited
	reg [1:0] nmi_sync_reg;
	wire nmi_edge_select = edge_mode_reg[`VIU_NMI_EDGE_BIT];
	// ==========================================
	// nmi edge detect, falling by default
	wire nmi_event = nmi_edge_select ? (nmi_sync_reg[0] & ~nmi_sync_reg[1])
		: (~nmi_sync_reg[0] & nmi_sync_reg[1]);
	// ==========================================
	// external pins through filter and edge detector
	wire [`VIU_NUM_EXT-1:0] ext_edge;
	wire [`VIU_NUM_EXT-1:0] ext_pin_mux;
	genvar g;
	generate
		for (g = 0; g < `VIU_NUM_EXT; g = g + 1) begin : g_ext
			// one pin slot carries the selectable capture input
			assign ext_pin_mux[g] = (g == 5) ? (capture_pin_select_reg ? capture_request_b_i
				: capture_request_a_i) : ext_pin_i[g];
			viu_edge_filter u_filt (
				.core_clk_i(core_clk_i),
				.rst_n_i(rst_n_i),
				.pin_i(ext_pin_mux[g]),
				.rise_sel_i(edge_mode_reg[g+1]),
				.edge_o(ext_edge[g])
			);
		end
	endgenerate
	// ext index to default number: 0..4, 12, 17..21, fixed wiring
	reg [`VIU_NUM_SRC-1:0] raw_req;
	integer e;
	always @* begin
		raw_req = periph_req_i;
		for (e = 0; e < 5; e = e + 1) raw_req[e] = periph_req_i[e] | ext_edge[e];
		raw_req[`VIU_CAP_SRC] = periph_req_i[`VIU_CAP_SRC] | ext_edge[5];
		for (e = 6; e < `VIU_NUM_EXT; e = e + 1) raw_req[e+11] = periph_req_i[e+11] | ext_edge[e];
	end
	// ==========================================
	// arbitration; highest in-service level blocks equal or lower
	wire [`VIU_NUM_SRC-1:0] cand = pend_reg & ~mask_reg;
	wire found;
	wire [5:0] win_idx;
	wire [2:0] win_lvl;
	viu_prio_pick u_pick (
		.cand_i(cand),
		.prio_i(prio_reg),
		.found_o(found),
		.idx_o(win_idx),
		.lvl_o(win_lvl)
	);
	reg [3:0] top_lvl; // 8 means nothing in service
	integer l;
	always @* begin
		top_lvl = 4'h8;
		for (l = 7; l >= 0; l = l - 1) if (isp_reg[l]) top_lvl = l[3:0];
	end
	wire mask_ok = found && !psw_id_i && !psw_np_i && ({1'b0, win_lvl} < top_lvl);
	wire nmi_ok = nmi_pend_reg && !nmi_busy_reg;
	wire lat_ok = (lat_cnt_reg >= `VIU_MIN_LAT_CYC - 1);
	wire [31:0] ret_pc = abortable_insn_i ? current_instruction_address_i
		: following_instruction_address_i;
	wire [7:0] win_slot = slot_of(win_idx);
	// ==========================================
	// main sequential process
	integer s;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_reg <= {`VIU_NUM_SRC{1'b1}};
			pend_reg <= {`VIU_NUM_SRC{1'b0}};
			prio_reg <= {`VIU_NUM_SRC{`VIU_PRIO_RST}};
			edge_mode_reg <= {(`VIU_NUM_EXT+1){1'b0}};
			capture_pin_select_reg <= 1'b0;
			nmi_pend_reg <= 1'b0;
			nmi_busy_reg <= 1'b0;
			isr_reg <= {`VIU_NUM_SRC{1'b0}};
			isp_reg <= 8'h00;
			lat_cnt_reg <= 3'h0;
			nmi_sync_reg <= 2'b11;
			take_o <= 1'b0;
			exc_code_o <= `VIU_CODE_RESET;
			handler_o <= 32'h00000000;
			maskable_return_save_o <= 32'h00000000;
			nonmaskable_return_save_o <= 32'h00000000;
			debug_return_save_o <= 32'h00000000;
			in_service_lvl_o <= 3'h7;
			in_service_o <= 1'b0;
			avs_readdata_o <= 32'h00000000;
			avs_waitrequest_o <= 1'b1;
		end else begin
			nmi_sync_reg <= {nmi_sync_reg[0], port0_bit0_pin_i};
			take_o <= 1'b0;
			// latch pending; a new event wins over the acknowledge clear
			pend_reg <= pend_reg | raw_req;
			if (nmi_event) nmi_pend_reg <= 1'b1; // only one kept
			// latency counter: shared by all requests and cleared only on an nmi or maskable take; the first one counted after such a take waits at least four cycles
			if ((nmi_pend_reg || |cand) && !lat_ok) lat_cnt_reg <= lat_cnt_reg + 3'h1;
			// ---- exceptions first, they come from the executing instruction
			if (illegal_or_debug_trap_i) begin
				take_o <= 1'b1;
				exc_code_o <= `VIU_CODE_ILG;
				handler_o <= {16'h0000, `VIU_CODE_ILG};
				debug_return_save_o <= following_instruction_address_i + `VIU_ILG_PC_OFS;
			end else if (trap_i) begin
				take_o <= 1'b1;
				exc_code_o <= (trap_vector_i[4] ? `VIU_CODE_TRAP_HI : `VIU_CODE_TRAP_LO)
					| {12'h000, trap_vector_i[3:0]};
				handler_o <= trap_vector_i[4] ? {16'h0000, `VIU_CODE_TRAP_HI}
					: {16'h0000, `VIU_CODE_TRAP_LO};
				maskable_return_save_o <= following_instruction_address_i;
			end else if (nmi_ok && lat_ok) begin
				take_o <= 1'b1;
				nmi_pend_reg <= nmi_event; // arrivals in this cycle survive
				nmi_busy_reg <= 1'b1;
				lat_cnt_reg <= 3'h0;
				exc_code_o <= `VIU_CODE_NMI;
				handler_o <= {16'h0000, `VIU_CODE_NMI};
				nonmaskable_return_save_o <= ret_pc;
			end else if (mask_ok && lat_ok && !nmi_busy_reg) begin
				take_o <= 1'b1;
				pend_reg <= (pend_reg & ~({{(`VIU_NUM_SRC-1){1'b0}}, 1'b1} << win_idx))
					| raw_req;
				isr_reg[win_idx] <= 1'b1;
				isp_reg[win_lvl] <= 1'b1;
				lat_cnt_reg <= 3'h0;
				exc_code_o <= {4'h0, win_slot, 4'h0};
				handler_o <= {20'h00000, win_slot, 4'h0};
				maskable_return_save_o <= ret_pc;
				in_service_lvl_o <= win_lvl;
			end
			// return: nmi ends first, else drop the top maskable level
			if (reti_i) begin
				if (nmi_busy_reg) begin
					nmi_busy_reg <= 1'b0;
				end else begin
					for (s = 0; s < `VIU_NUM_SRC; s = s + 1)
						if (isr_reg[s] && prio_reg[3*s +: 3] == top_lvl[2:0]) isr_reg[s] <= 1'b0;
					if (!top_lvl[3]) isp_reg[top_lvl[2:0]] <= 1'b0;
				end
			end
			in_service_o <= nmi_busy_reg | (|isp_reg);
			// ---- avalon slave: one wait cycle, answer on the second edge
			avs_waitrequest_o <= 1'b1;
			// the released cycle must re-arm the wait, so only a waiting request answers
			if ((avs_read_i || avs_write_i) && avs_waitrequest_o == 1'b1) begin
				avs_waitrequest_o <= 1'b0;
			end
			if (avs_write_i && !avs_waitrequest_o) begin
				case (avs_address_i)
					`VIU_OFF_MASK_LO: mask_reg[31:0] <= avs_writedata_i;
					`VIU_OFF_MASK_HI: mask_reg[46:32] <= avs_writedata_i[14:0];
					`VIU_OFF_EDGE_MODE: edge_mode_reg <= avs_writedata_i[`VIU_NUM_EXT:0];
					`VIU_OFF_CAP_SEL: capture_pin_select_reg <= avs_writedata_i[0];
					default: begin
						if (avs_address_i >= `VIU_OFF_PRIO_BASE && avs_address_i[1:0] == 2'b00
							&& avs_address_i[7:2] < 6'd63)
							prio_reg[3*(avs_address_i[7:2]-6'd16) +: 3] <= avs_writedata_i[2:0];
					end
				endcase
			end
			if (avs_read_i) begin
				case (avs_address_i)
					`VIU_OFF_MASK_LO: avs_readdata_o <= mask_reg[31:0];
					`VIU_OFF_MASK_HI: avs_readdata_o <= {17'h00000, mask_reg[46:32]};
					`VIU_OFF_PEND_LO: avs_readdata_o <= pend_reg[31:0];
					`VIU_OFF_PEND_HI: avs_readdata_o <= {17'h00000, pend_reg[46:32]};
					`VIU_OFF_EDGE_MODE: avs_readdata_o <= {20'h00000, edge_mode_reg};
					`VIU_OFF_PORT0: avs_readdata_o <= {31'h00000000, nmi_sync_reg[0]};
					`VIU_OFF_CAP_SEL: avs_readdata_o <= {31'h00000000, capture_pin_select_reg};
					`VIU_OFF_STATUS: avs_readdata_o <= {18'h00000, nmi_pend_reg, nmi_busy_reg,
						isp_reg, top_lvl[2:0], 1'b0};
					default: begin
						if (avs_address_i >= `VIU_OFF_PRIO_BASE && avs_address_i[7:2] < 6'd63)
							avs_readdata_o <= {29'h00000000,
								prio_reg[3*(avs_address_i[7:2]-6'd16) +: 3]};
						else
							avs_readdata_o <= 32'h00000000;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/viu_core_properties.sv
// property checker bound to the interrupt unit top
`timescale 1ns/100ps
`default_nettype none
module viu_core_properties (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [31:0] following_instruction_address_i,
	input wire logic trap_i,
	input wire logic [4:0] trap_vector_i,
	input wire logic illegal_or_debug_trap_i,
	input wire logic psw_np_i,
	input wire logic take_o,
	input wire logic [15:0] exc_code_o,
	input wire logic [31:0] handler_o,
	input wire logic [31:0] debug_return_save_o
);
	// ==========================================
	// single clock domain, reset silences all
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_trap_code: assert property (trap_i && !illegal_or_debug_trap_i && !psw_np_i |=>
		take_o && exc_code_o == 16'h0040 + $past(trap_vector_i)) else $error("trap code wrong");
	a_trap_handler: assert property (trap_i && !illegal_or_debug_trap_i && !psw_np_i |=>
		handler_o == ($past(trap_vector_i[4]) ? 32'h00000050 : 32'h00000040))
		else $error("trap handler wrong");
	a_illegal_vector: assert property (illegal_or_debug_trap_i && !psw_np_i |=>
		take_o && exc_code_o == 16'h0060 && handler_o == 32'h00000060) else $error("illegal vector");
	a_illegal_save: assert property (take_o && exc_code_o == 16'h0060 |->
		debug_return_save_o == $past(following_instruction_address_i) + 32'h00000004)
		else $error("illegal save wrong");
	a_maskable_vector: assert property (take_o && exc_code_o[15:7] != 9'h000 |->
		handler_o == {16'h0000, exc_code_o} && exc_code_o[3:0] == 4'h0) else $error("vector mismatch");
	a_nmi_vector: assert property (take_o && exc_code_o == 16'h0010 |-> handler_o == 32'h00000010)
		else $error("nmi handler wrong");
	a_reset_quiet: assert property ($rose(rst_n_i) |-> !take_o && avs_waitrequest_o &&
		exc_code_o == 16'h0000 && handler_o == 32'h00000000) else $error("reset vector wrong");
	a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o) else $error("bus answer late");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low long");
	a_read_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("readdata moved");
endmodule
bind viu_core viu_core_properties chk_u (.core_clk_i, .rst_n_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .following_instruction_address_i, .trap_i, .trap_vector_i,
	.illegal_or_debug_trap_i, .psw_np_i, .take_o, .exc_code_o, .handler_o, .debug_return_save_o);
`default_nettype wire

// File: tb/viu_cpu_model.sv
// behavioural cpu core facing the interrupt unit
`timescale 1ns/100ps
`default_nettype none
module viu_cpu_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic take_i,
	input wire logic [15:0] exc_code_i,
	input wire logic [31:0] handler_i,
	input wire logic ret_i,
	input wire logic abort_i,
	output logic [31:0] following_instruction_address_o,
	output logic [31:0] current_instruction_address_o,
	output logic abortable_insn_o,
	output logic psw_id_o,
	output logic psw_np_o,
	output logic reti_o
);
	// pc parks while idle so saved addresses stay predictable
	logic [31:0] pc_reg;
	assign current_instruction_address_o = pc_reg;
	assign following_instruction_address_o = pc_reg + 32'h00000004;
	assign abortable_insn_o = abort_i;
	// ==========================================
	// handler entry and return
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_reg <= 32'h00001000;
			psw_id_o <= 1'b0;
			psw_np_o <= 1'b0;
			reti_o <= 1'b0;
		end else begin
			reti_o <= ret_i;
			if (take_i) begin
				pc_reg <= handler_i;
				// nmi blocks all, maskable entry only disables
				if (exc_code_i == 16'h0010 || exc_code_i[15:7] != 9'h000) psw_id_o <= 1'b1;
				if (exc_code_i == 16'h0010) psw_np_o <= 1'b1;
			end else if (ret_i) begin
				// no nesting in the bench, so return clears both
				psw_np_o <= 1'b0;
				psw_id_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/viu_core_tb_top.sv
// self-checking bench for the interrupt unit
`timescale 1ns/100ps
`default_nettype none
`include "viu_consts.vh"
module viu_core_tb_top;
	logic core_clk, rst_n, rd, wr, wait_w, pin, trap, ill, take, ret_cmd, abort;
	logic capa, capb;
	logic [10:0] ext;
	logic abt, id, np, reti;
	logic [7:0] addr;
	logic [4:0] tvec;
	logic [15:0] code;
	logic [31:0] wdata, rdata, hnd, msave, nsave, dsave, fol, cur, rv, fol_exp;
	logic [46:0] periph;
	integer failures = 0;
	integer samples_checked = 0;
	integer n, i;
	viu_core dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
		.port0_bit0_pin_i(pin), .ext_pin_i(ext), .capture_request_a_i(capa),
		.capture_request_b_i(capb), .periph_req_i(periph), .following_instruction_address_i(fol),
		.current_instruction_address_i(cur), .abortable_insn_i(abt), .trap_i(trap),
		.trap_vector_i(tvec), .illegal_or_debug_trap_i(ill), .psw_id_i(id), .psw_np_i(np),
		.reti_i(reti), .take_o(take), .exc_code_o(code), .handler_o(hnd),
		.maskable_return_save_o(msave), .nonmaskable_return_save_o(nsave),
		.debug_return_save_o(dsave), .in_service_lvl_o(), .in_service_o());
	viu_cpu_model cpu_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .take_i(take), .exc_code_i(code),
		.handler_i(hnd), .ret_i(ret_cmd), .abort_i(abort), .following_instruction_address_o(fol),
		.current_instruction_address_o(cur), .abortable_insn_o(abt), .psw_id_o(id),
		.psw_np_o(np), .reti_o(reti));
	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		do @(posedge core_clk); while (wait_w !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wait_take(output integer c);
		c = 0;
		do begin
			@(posedge core_clk);
			c++;
		end while (take !== 1'b1 && c < 300);
		check(c < 300, 1);
		#1;
	endtask
	task automatic quiet(input integer k);
		repeat (k) begin
			@(posedge core_clk);
			check(take, 1'b0);
		end
	endtask
	task automatic fire(input logic [46:0] b);
		@(posedge core_clk);
		periph <= b;
		@(posedge core_clk);
		periph <= '0;
	endtask
	task automatic ret();
		@(posedge core_clk);
		ret_cmd <= 1'b1;
		@(posedge core_clk);
		ret_cmd <= 1'b0;
	endtask
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ==========================================
	// clock and watchdog
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		{rst_n, rd, wr, trap, ill, ret_cmd, abort} = '0;
		{addr, tvec, wdata, periph} = '0;
		pin = 1'b1;
		// pins idle high so the falling-edge default sees no edge after reset
		ext = 11'h7FF;
		capa = 1'b1;
		capb = 1'b1;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(0, `VIU_OFF_MASK_LO, 0);
		check(rv, `VIU_MASK_RST);
		bus(0, `VIU_OFF_PRIO_BASE, 0);
		check(rv, {29'h0, `VIU_PRIO_RST});
		bus(0, `VIU_OFF_EDGE_MODE, 0);
		check(rv, 32'h00000000);
		bus(0, `VIU_OFF_PORT0, 0);
		check(rv, 32'h00000001);
		bus(1, 8'hFC, 32'hFFFFFFFF);
		bus(0, 8'hFC, 0);
		check(rv, 32'h00000000);
		// every trap vector, both groups
		for (i = 0; i < 32; i++) begin
			@(posedge core_clk);
			trap <= 1'b1;
			tvec <= i[4:0];
			@(posedge core_clk);
			trap <= 1'b0;
			wait_take(n);
			check(code, 32'h00000040 + i);
			check(hnd, i < 16 ? 32'h00000040 : 32'h00000050);
		end
		fol_exp = fol + 32'h00000004;
		@(posedge core_clk);
		ill <= 1'b1;
		@(posedge core_clk);
		ill <= 1'b0;
		wait_take(n);
		check(code, 32'h00000060);
		check(dsave, fol_exp);
		// masked source stays pending until opened
		bus(1, `VIU_OFF_MASK_HI, 32'h00000000);
		fire(47'h000000000001);
		quiet(10);
		bus(0, `VIU_OFF_PEND_LO, 0);
		check(rv, 32'h00000001);
		fol_exp = fol;
		bus(1, `VIU_OFF_MASK_LO, 32'h00000000);
		wait_take(n);
		check(code, 32'h00000080);
		check(msave, fol_exp);
		bus(0, `VIU_OFF_PEND_LO, 0);
		check(rv, 32'h00000000);
		ret();
		// same-cycle pair: default order, then level 0 on source 46
		for (i = 0; i < 2; i++) begin
			if (i == 1) bus(1, 8'hF8, 32'h00000000);
			fire(47'h400000000020);
			wait_take(n);
			check(n >= 5, 1);
			check(code, i == 1 ? 32'h00000450 : 32'h000000F0);
			ret();
			wait_take(n);
			check(code, i == 1 ? 32'h000000F0 : 32'h00000450);
			ret();
			quiet(10);
		end
		// filtered pin edges: pin 0, then capture pin b ignored while a is chosen
		@(posedge core_clk);
		ext <= 11'h7FE;
		capb <= 1'b0;
		wait_take(n);
		check(code, 32'h00000080);
		ret();
		quiet(10);
		@(posedge core_clk);
		capa <= 1'b0;
		wait_take(n);
		check(code, 32'h00000160);
		ret();
		// nmi on falling edge while an abortable insn runs
		@(posedge core_clk);
		abort <= 1'b1;
		fol_exp = cur;
		pin <= 1'b0;
		wait_take(n);
		check(code, 32'h00000010);
		check(nsave, fol_exp);
		bus(0, `VIU_OFF_PORT0, 0);
		check(rv, 32'h00000000);
		repeat (2) begin
			@(posedge core_clk);
			pin <= 1'b1;
			abort <= 1'b0;
			quiet(6);
			pin <= 1'b0;
			quiet(6);
		end
		ret();
		wait_take(n);
		check(code, 32'h00000010);
		ret();
		quiet(20);
		bus(1, `VIU_OFF_EDGE_MODE, 32'h00000001);
		bus(0, `VIU_OFF_EDGE_MODE, 0);
		check(rv, 32'h00000001);
		@(posedge core_clk);
		pin <= 1'b1;
		wait_take(n);
		check(code, 32'h00000010);
		ret();
		print_verdict();
	end
endmodule
`default_nettype wire
